// ===== verilog/usb_dma_bridge_status.sv
/*
 * Master status and debug timeout view of the USB DMA bridge,
 * with a small register port and one level interrupt.
 * Assumes endpoint flags and the USB clock arrive asynchronously
 * and the two DMA buffer flags come from logic on REF_CLK.
 * The USB clock is sampled, so it must be well below REF_CLK/2.
 */
// Our own choices: the plain strobed port and the register offsets.
module usb_dma_bridge_status (
    input  wire logic        REF_CLK,      // bus clock, 200 MHz
    input  wire logic        RESETN,       // async reset, low
    input  wire logic [7:0]  REG_ADDR,     // register byte address
    input  wire logic [31:0] REG_WDATA,    // write data
    input  wire logic        REG_WR,       // write strobe
    input  wire logic        REG_RD,       // read strobe
    output logic      [31:0] REG_RDATA,    // read data, next cycle
    output logic             IRQ,          // level interrupt
    input  wire logic        EPTX_EMPTY,   // core: tx endpoint empty
    input  wire logic        EPTX_DSET,    // core: tx endpoint full
    input  wire logic        EPRX_DSET,    // core: rx data waiting
    input  wire logic        USB_CLK,      // core clock, sampled
    input  wire logic        MRD_BUF_EMPTY,// read DMA buffer empty
    input  wire logic        MWR_BUF_EMPTY,// write DMA buffer empty
    output logic             MRD_XFER_OK,  // read DMA may load tx
    output logic             ZERO_LEN_TX   // zero-length send pulse
);
    // ========================================================
    // state of the block
    typedef struct packed {
        logic [31:0]                       rdata;
        logic                              irq;
        logic                              xfer_ok;
        logic                              zlp;
        logic                              tmo_en;
        logic [usb_dma_status_pkg::ADDR_W-1:0] req_addr;
        logic [31:0]                       rd_value;
        logic [usb_dma_status_pkg::EV_W-1:0] irq_status;
        logic [usb_dma_status_pkg::EV_W-1:0] irq_mask;
        usb_dma_status_pkg::ep_flags_t     prev;
        logic                              prev_usb;
    } blk_state_t;

    blk_state_t st;
    blk_state_t next_st;

    usb_dma_status_pkg::reg_req_t  req;
    usb_dma_status_pkg::ep_flags_t flags;
    logic                          usb_lvl;
    logic                          usb_tick;
    logic                          tmr_start;
    logic                          tmr_reload;
    logic [usb_dma_status_pkg::CNT_W-1:0] tmr_count;
    logic                          tmr_expired;
    logic [31:0]                   status_word;
    logic [usb_dma_status_pkg::EV_W-1:0] events;

    // bundle the register port
    assign req.addr  = REG_ADDR;
    assign req.wdata = REG_WDATA;
    assign req.wr    = REG_WR;
    assign req.rd    = REG_RD;

    // ========================================================
    // crossing: endpoint flags and sampled USB clock
    level_sync #(
        .W         (4),
        .RESET_VAL ({1'b0, usb_dma_status_pkg::EP_FLAGS_RESET})
    ) u_sync (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .d     ({USB_CLK, EPTX_EMPTY, EPTX_DSET, EPRX_DSET}),
        .q     ({usb_lvl, flags})
    );

    // ========================================================
    // timeout counter runs once rx endpoint drains
    assign usb_tick   = usb_lvl & ~st.prev_usb;
    assign tmr_start  = st.prev.rx_dset & ~flags.rx_dset;
    assign tmr_reload = flags.rx_dset & ~st.prev.rx_dset;

    rx_timeout_timer #(
        .CW (usb_dma_status_pkg::CNT_W)
    ) u_timer (
        .clk     (REF_CLK),
        .rst_n   (RESETN),
        .tick    (usb_tick),
        .start   (tmr_start),
        .reload  (tmr_reload),
        .count   (tmr_count),
        .expired (tmr_expired)
    );

    // ========================================================
    // master status word; upper bits tied to zero
    always_comb begin
        status_word = usb_dma_status_pkg::ZERO_WORD;
        status_word[usb_dma_status_pkg::ST_TX_EMPTY] =
            flags.tx_empty;
        status_word[usb_dma_status_pkg::ST_MRD_EMPTY] =
            MRD_BUF_EMPTY;
        status_word[usb_dma_status_pkg::ST_MWR_EMPTY] =
            MWR_BUF_EMPTY;
        status_word[usb_dma_status_pkg::ST_TX_DSET] =
            flags.tx_dset;
        status_word[usb_dma_status_pkg::ST_RX_DSET] =
            flags.rx_dset;
    end

    // ========================================================
    // interrupt events taken from synchronised edges and the timer expiry pulse
    always_comb begin
        events = usb_dma_status_pkg::EV_NONE;
        events[usb_dma_status_pkg::EV_TX_EMPTY] =
            flags.tx_empty & ~st.prev.tx_empty;
        events[usb_dma_status_pkg::EV_RX_DSET] =
            flags.rx_dset & ~st.prev.rx_dset;
        events[usb_dma_status_pkg::EV_TX_SENT] =
            st.prev.tx_dset & ~flags.tx_dset;
        events[usb_dma_status_pkg::EV_TIMEOUT] = tmr_expired;
    end

    // ========================================================
    // read decode; the counter has no direct window
    function automatic logic [31:0] read_mux(
        input logic [7:0]  addr,
        input logic [31:0] status,
        input blk_state_t  s
    );
        logic [31:0] v;
        v = usb_dma_status_pkg::ZERO_WORD;
        unique case (addr)
            usb_dma_status_pkg::OFS_MST_STATUS: begin
                v = status;
            end
            usb_dma_status_pkg::OFS_WR_TMO_CTL: begin
                v[usb_dma_status_pkg::CTL_TMO_EN] = s.tmo_en;
            end
            usb_dma_status_pkg::OFS_RD_REQUEST: begin
                v[7:0] = s.req_addr;
            end
            usb_dma_status_pkg::OFS_RD_VALUE: begin
                v = s.rd_value;
            end
            usb_dma_status_pkg::OFS_IRQ_STATUS: begin
                v[usb_dma_status_pkg::EV_W-1:0] = s.irq_status;
            end
            usb_dma_status_pkg::OFS_IRQ_MASK: begin
                v[usb_dma_status_pkg::EV_W-1:0] = s.irq_mask;
            end
            default: begin
                v = usb_dma_status_pkg::ZERO_WORD;
            end
        endcase
        return v;
    endfunction : read_mux

    // ========================================================
    // next state of the register file and outputs
    always_comb begin
        next_st          = st;
        next_st.prev     = flags;
        next_st.prev_usb = usb_lvl;
        next_st.zlp      = 1'b0;
        // read data stand for exactly one cycle
        next_st.rdata    = usb_dma_status_pkg::ZERO_WORD;
        if (req.rd) begin
            next_st.rdata = read_mux(req.addr, status_word, st);
        end
        if (req.wr) begin
            unique case (req.addr)
                usb_dma_status_pkg::OFS_WR_TMO_CTL: begin
                    next_st.tmo_en =
                        req.wdata[usb_dma_status_pkg::CTL_TMO_EN];
                end
                usb_dma_status_pkg::OFS_RD_REQUEST: begin
                    next_st.req_addr = req.wdata[7:0];
                    next_st.rd_value = usb_dma_status_pkg::ZERO_WORD;
                    if (req.wdata[7:0] ==
                        usb_dma_status_pkg::OFS_RX_TMO_CNT &&
                        st.tmo_en) begin
                        next_st.rd_value = tmr_count;
                    end
                end
                usb_dma_status_pkg::OFS_CORE_ST_SET: begin
                    // caller must see tx empty first
                    next_st.zlp =
                        req.wdata[usb_dma_status_pkg::CSS_ZERO_LEN];
                end
                usb_dma_status_pkg::OFS_IRQ_MASK: begin
                    next_st.irq_mask =
                        req.wdata[usb_dma_status_pkg::EV_W-1:0];
                end
                default: begin
                    // status and reserved bits ignore writes
                    next_st.irq_mask = st.irq_mask;
                end
            endcase
        end
        // read clears, but a fresh event still lands
        if (req.rd && req.addr == usb_dma_status_pkg::OFS_IRQ_STATUS) begin
            next_st.irq_status = events;
        end else begin
            next_st.irq_status = st.irq_status | events;
        end
        next_st.irq     = |(next_st.irq_status & next_st.irq_mask);
        next_st.xfer_ok = ~flags.tx_dset;
    end

    // ========================================================
    // register stage
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st.rdata      <= usb_dma_status_pkg::ZERO_WORD;
            st.irq        <= 1'b0;
            st.xfer_ok    <= 1'b1;
            st.zlp        <= 1'b0;
            st.tmo_en     <= 1'b0;
            st.req_addr   <= 8'h00;
            st.rd_value   <= usb_dma_status_pkg::ZERO_WORD;
            st.irq_status <= usb_dma_status_pkg::EV_NONE;
            st.irq_mask   <= usb_dma_status_pkg::EV_NONE;
            st.prev       <= usb_dma_status_pkg::EP_FLAGS_RESET;
            st.prev_usb   <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flip-flops
    assign REG_RDATA   = st.rdata;
    assign IRQ         = st.irq;
    assign MRD_XFER_OK = st.xfer_ok;
    assign ZERO_LEN_TX = st.zlp;
endmodule : usb_dma_bridge_status

// ===== verilog/usb_dma_status_pkg.sv
/*
 * Constants, field layouts and carrier types of the USB DMA bridge
 * status block. Assumes one bus clock; only endpoint flags and USB clock are async.
 */
//Contract
//- bit 4 shows transmit endpoint empty
//- bit 3 shows read DMA buffer empty
//- bit 2 shows write DMA buffer empty
//- bit 1 sets when transmit endpoint full
//- bit 1 clears after IN token sent
//- read DMA allowed only while bit 1 low
//- bit 0 sets when receive data arrives
//- bit 0 clears after DMA drains receive
//- endpoint bits are synchronised core inputs
//- debug counter decrements per USB clock
//- counter visible only with timeout enable
//- counter read via request then value register
package usb_dma_status_pkg;
    // ========================================================
    // register map (byte offsets)
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_MST_STATUS  = 8'h00;
    localparam logic [7:0] OFS_WR_TMO_CTL  = 8'h04;
    localparam logic [7:0] OFS_RD_REQUEST  = 8'h08;
    localparam logic [7:0] OFS_RX_TMO_CNT  = 8'h0C;
    localparam logic [7:0] OFS_RD_VALUE    = 8'h10;
    localparam logic [7:0] OFS_CORE_ST_SET = 8'h14;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h1C;
    // ========================================================
    // field positions
    localparam int ST_TX_EMPTY  = 4;
    localparam int ST_MRD_EMPTY = 3;
    localparam int ST_MWR_EMPTY = 2;
    localparam int ST_TX_DSET   = 1;
    localparam int ST_RX_DSET   = 0;
    localparam int CTL_TMO_EN   = 0;
    localparam int CSS_ZERO_LEN = 0;
    localparam int EV_TX_EMPTY  = 0;
    localparam int EV_RX_DSET   = 1;
    localparam int EV_TX_SENT   = 2;
    localparam int EV_TIMEOUT   = 3;
    localparam int EV_W         = 4;
    // ========================================================
    // reset values and widths
    localparam int CNT_W = 32;
    localparam logic [31:0] CNT_RESET = 32'hFFFFFFFF;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;
    localparam logic [EV_W-1:0] EV_NONE = 4'h0;
    // ========================================================
    // carriers
    typedef struct packed {
        logic tx_empty;
        logic tx_dset;
        logic rx_dset;
    } ep_flags_t;
    localparam ep_flags_t EP_FLAGS_RESET = 3'h4;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;
    typedef enum logic [1:0] {
        CNT_IDLE = 2'b00,
        CNT_RUN  = 2'b01,
        CNT_DONE = 2'b10
    } cnt_state_t;
endpackage : usb_dma_status_pkg

// ===== verilog/level_sync.sv
/*
 * Two-stage synchroniser for a vector of async levels.
 * Assumes the inputs are slow against the sampling clock.
 */
module level_sync #(
    parameter int          W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         clk,   // sampling clock
    input  wire logic         rst_n, // async reset, low
    input  wire logic [W-1:0] d,     // async levels
    output logic      [W-1:0] q      // synchronised levels
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // ========================================================
    // first stage feeds only the second stage
    always_comb begin
        next_st.meta   = d;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= {RESET_VAL, RESET_VAL};
        end else begin
            st <= next_st;
        end
    end

    assign q = st.stable;
endmodule : level_sync

// ===== verilog/rx_timeout_timer.sv
/*
 * Debug down-counter for the receive endpoint timeout.
 * Assumes tick is a one-cycle pulse per rising USB clock edge.
 */
module rx_timeout_timer #(
    parameter int CW = usb_dma_status_pkg::CNT_W
) (
    input  wire logic          clk,     // bus clock
    input  wire logic          rst_n,   // async reset, low
    input  wire logic          tick,    // one USB clock edge
    input  wire logic          start,   // endpoint became empty
    input  wire logic          reload,  // endpoint refilled
    output logic      [CW-1:0] count,   // current value
    output logic               expired  // pulse on reaching 0
);
    typedef struct packed {
        usb_dma_status_pkg::cnt_state_t fsm;
        logic [CW-1:0]                  count;
        logic                           expired;
    } tmr_state_t;

    tmr_state_t st;
    tmr_state_t next_st;

    // ========================================================
    // reload wins so a refill never leaves a stale count
    always_comb begin
        next_st         = st;
        next_st.expired = 1'b0;
        if (reload) begin
            next_st.fsm   = usb_dma_status_pkg::CNT_IDLE;
            next_st.count = CW'(usb_dma_status_pkg::CNT_RESET);
        end else begin
            unique case (st.fsm)
                usb_dma_status_pkg::CNT_IDLE: begin
                    if (start) begin
                        next_st.fsm = usb_dma_status_pkg::CNT_RUN;
                    end
                end
                usb_dma_status_pkg::CNT_RUN: begin
                    if (tick) begin
                        next_st.count = st.count - CW'(1);
                        if (st.count == CW'(1)) begin
                            next_st.fsm     = usb_dma_status_pkg::CNT_DONE;
                            next_st.expired = 1'b1;
                        end
                    end
                end
                usb_dma_status_pkg::CNT_DONE: begin
                    next_st.fsm = usb_dma_status_pkg::CNT_DONE;
                end
                default: begin
                    next_st.fsm = usb_dma_status_pkg::CNT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st.fsm     <= usb_dma_status_pkg::CNT_IDLE;
            st.count   <= CW'(usb_dma_status_pkg::CNT_RESET);
            st.expired <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign count   = st.count;
    assign expired = st.expired;
endmodule : rx_timeout_timer

// ===== sim/usb_core_model.sv
/*
 * Behavioural USB device core: endpoint levels and a USB clock.
 * Assumes the bench paces it through its tasks on the bus clock.
 */
module usb_core_model (
    input  wire logic clk,         // bus clock, pacing and send count
    input  wire logic zero_len_tx, // zero-length send command
    output logic      ep_tx_empty, // tx endpoint empty
    output logic      ep_tx_dset,  // tx endpoint full
    output logic      ep_rx_dset,  // rx data waiting
    output logic      usb_clk,     // core clock, bursts only
    output int        zlp_seen     // zero-length sends taken
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // levels start as an idle core: empty, nothing set
    initial begin
        ep_tx_empty = 1'b1;
        ep_tx_dset  = 1'b0;
        ep_rx_dset  = 1'b0;
        usb_clk     = 1'b0;
    end
    // a full tx endpoint is never empty; caller keeps that pairing
    task automatic set_ep(input logic te, input logic td, input logic rx);
        @(posedge clk);
        ep_tx_empty <= te;
        ep_tx_dset  <= td;
        ep_rx_dset  <= rx;
    endtask : set_ep
    // clock stands low between bursts, 8 bus cycles a period
    task automatic ticks(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            usb_clk <= 1'b1;
            repeat (4) @(posedge clk);
            usb_clk <= 1'b0;
        end
    endtask : ticks
    // count sends; one taken while data waits would be lost data
    always @(posedge clk) begin
        if (zero_len_tx && ep_tx_empty)
            zlp_seen <= zlp_seen + 1;
    end
endmodule : usb_core_model

// ===== sim/usb_dma_bridge_status_properties.sv
/*
 * Port checks of the bridge status block.
 * Assumes one bus clock and the package register map.
 */
module usb_dma_status_properties (
    input wire logic        REF_CLK,       // bus clock
    input wire logic        RESETN,        // async reset, low
    input wire logic [7:0]  REG_ADDR,      // address
    input wire logic [31:0] REG_WDATA,     // write data
    input wire logic        REG_WR,        // write strobe
    input wire logic        REG_RD,        // read strobe
    input wire logic [31:0] REG_RDATA,     // read data
    input wire logic        IRQ,           // interrupt
    input wire logic        EPTX_EMPTY,    // tx empty
    input wire logic        EPTX_DSET,     // tx full
    input wire logic        EPRX_DSET,     // rx waiting
    input wire logic        USB_CLK,       // core clock
    input wire logic        MRD_BUF_EMPTY, // read buffer empty
    input wire logic        MWR_BUF_EMPTY, // write buffer empty
    input wire logic        MRD_XFER_OK,   // read DMA gate
    input wire logic        ZERO_LEN_TX    // zero-length pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] A_ST  = usb_dma_status_pkg::OFS_MST_STATUS;
    localparam logic [7:0] A_CTL = usb_dma_status_pkg::OFS_WR_TMO_CTL;
    localparam logic [7:0] A_REQ = usb_dma_status_pkg::OFS_RD_REQUEST;
    localparam logic [7:0] A_CNT = usb_dma_status_pkg::OFS_RX_TMO_CNT;
    localparam logic [7:0] A_VAL = usb_dma_status_pkg::OFS_RD_VALUE;
    localparam logic [7:0] A_ZLT = usb_dma_status_pkg::OFS_CORE_ST_SET;
    logic en_now;
    logic en_req;
    wire  rd_st = REG_RD && REG_ADDR == A_ST;
    // ==========================================================
    // enable as last written and as seen by the last request
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            en_now <= 1'b0;
            en_req <= 1'b0;
        end else begin
            if (REG_WR && REG_ADDR == A_CTL)
                en_now <= REG_WDATA[0];
            if (REG_WR && REG_ADDR == A_REQ)
                en_req <= en_now;
        end
    end
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESETN);
    // ==========================================================
    // a pin held long enough to pass the synchroniser, then read
    sequence s_calm_rd(sig);
        $stable(sig)[*4] ##0 rd_st;
    endsequence
    a_tx_empty_bit: assert property (s_calm_rd(EPTX_EMPTY) |=>
        REG_RDATA[4] == $past(EPTX_EMPTY)) else $error("tx empty bit");
    a_tx_dset_bit: assert property (s_calm_rd(EPTX_DSET) |=>
        REG_RDATA[1] == $past(EPTX_DSET)) else $error("tx set bit");
    a_rx_dset_bit: assert property (s_calm_rd(EPRX_DSET) |=>
        REG_RDATA[0] == $past(EPRX_DSET)) else $error("rx set bit");
    a_mrd_buf_bit: assert property (rd_st && $stable(MRD_BUF_EMPTY) |=>
        REG_RDATA[3] == $past(MRD_BUF_EMPTY)) else $error("rd buf bit");
    a_mwr_buf_bit: assert property (rd_st && $stable(MWR_BUF_EMPTY) |=>
        REG_RDATA[2] == $past(MWR_BUF_EMPTY)) else $error("wr buf bit");
    a_rsvd_zero: assert property (rd_st |=> REG_RDATA[31:5] == 27'h0)
        else $error("reserved bits set");
    a_ctr_hidden: assert property (REG_RD && REG_ADDR == A_CNT |=>
        REG_RDATA == 32'h0) else $error("counter read direct");
    a_ctr_gated: assert property (REG_RD && REG_ADDR == A_VAL &&
        !en_now && !en_req |=> REG_RDATA == 32'h0) else $error("gated value");
    a_xfer_gate: assert property ($stable(EPTX_DSET)[*4] |->
        MRD_XFER_OK == !EPTX_DSET) else $error("read DMA gate");
    a_zero_pulse: assert property (REG_WR && REG_ADDR == A_ZLT &&
        REG_WDATA[0] |=> ZERO_LEN_TX ##1 !ZERO_LEN_TX) else $error("zlp pulse");
    a_reset_out: assert property ($rose(RESETN) |-> MRD_XFER_OK &&
        !IRQ && !ZERO_LEN_TX && REG_RDATA == 32'h0) else $error("reset out");
endmodule : usb_dma_status_properties

bind usb_dma_bridge_status usb_dma_status_properties i_props (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .IRQ(IRQ), .EPTX_EMPTY(EPTX_EMPTY),
    .EPTX_DSET(EPTX_DSET), .EPRX_DSET(EPRX_DSET), .USB_CLK(USB_CLK),
    .MRD_BUF_EMPTY(MRD_BUF_EMPTY), .MWR_BUF_EMPTY(MWR_BUF_EMPTY),
    .MRD_XFER_OK(MRD_XFER_OK), .ZERO_LEN_TX(ZERO_LEN_TX));

// ===== sim/usb_dma_bridge_status_tb.sv
/*
 * Self-checking bench of the bridge status block.
 * Assumes the core model drives all endpoint pins and USB_CLK.
 */
module usb_dma_bridge_status_tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic te; logic mrd; logic mwr; logic td; logic rx;
        logic [31:0] exp;
    } row_t;
    // inputs in status bit order, then the status they should read
    row_t rows [5] = '{{5'h1C, 32'h0000001C}, {5'h0A, 32'h0000000A},
        {5'h07, 32'h00000007}, {5'h11, 32'h00000011},
        {5'h1C, 32'h0000001C}};
    logic REF_CLK = 1'b0; // only the clock process drives it afterwards
    logic RESETN, REG_WR, REG_RD, MRD_BUF_EMPTY, MWR_BUF_EMPTY;
    logic [7:0] REG_ADDR;
    logic [31:0] REG_WDATA, d;
    wire logic [31:0] REG_RDATA;
    wire logic IRQ, EPTX_EMPTY, EPTX_DSET, EPRX_DSET, USB_CLK;
    wire logic MRD_XFER_OK, ZERO_LEN_TX;
    int zlp_seen, err_total, checks;
    usb_dma_bridge_status i_dut (.REF_CLK(REF_CLK), .RESETN(RESETN),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ),
        .EPTX_EMPTY(EPTX_EMPTY), .EPTX_DSET(EPTX_DSET),
        .EPRX_DSET(EPRX_DSET), .USB_CLK(USB_CLK),
        .MRD_BUF_EMPTY(MRD_BUF_EMPTY), .MWR_BUF_EMPTY(MWR_BUF_EMPTY),
        .MRD_XFER_OK(MRD_XFER_OK), .ZERO_LEN_TX(ZERO_LEN_TX));
    usb_core_model i_core (.clk(REF_CLK), .zero_len_tx(ZERO_LEN_TX),
        .ep_tx_empty(EPTX_EMPTY), .ep_tx_dset(EPTX_DSET),
        .ep_rx_dset(EPRX_DSET), .usb_clk(USB_CLK), .zlp_seen(zlp_seen));
    // ==========================================================
    // bus clock, 5 ns
    always #2.5 REF_CLK = ~REF_CLK;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one-cycle strobes, changed right after an edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge REF_CLK);
        REG_WR <= 1'b1; REG_ADDR <= a; REG_WDATA <= v;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge REF_CLK);
        REG_RD <= 1'b1; REG_ADDR <= a;
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
        #1 v = REG_RDATA;
    endtask : rd
    task automatic cnt_read(output logic [31:0] v);
        wr(8'h08, 32'h0000000C);
        rd(8'h10, v);
    endtask : cnt_read
    task automatic waitc(input int n);
        repeat (n) @(posedge REF_CLK);
    endtask : waitc
    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    // ==========================================================
    // watchdog: a hang counts as a mismatch
    initial begin
        waitc(20000);
        err_total++;
        $display("Error t=%0t watchdog expired", $time);
        end_of_test();
    end
    // ==========================================================
    // main sequence
    initial begin
        RESETN = 1'b0; REG_WR = 1'b0; REG_RD = 1'b0;
        REG_ADDR = 8'h00; REG_WDATA = 32'h0;
        MRD_BUF_EMPTY = 1'b1; MWR_BUF_EMPTY = 1'b1;
        waitc(3);
        RESETN <= 1'b1;
        rd(8'h00, d); chk(d, 32'h0000001C);
        wr(8'h04, 32'h1); cnt_read(d); chk(d, 32'hFFFFFFFF);
        $display("done: reset values");
        // status table
        for (int i = 0; i < 5; i++) begin
            @(posedge REF_CLK);
            MRD_BUF_EMPTY <= rows[i].mrd; MWR_BUF_EMPTY <= rows[i].mwr;
            i_core.set_ep(rows[i].te, rows[i].td, rows[i].rx);
            waitc(5);
            rd(8'h00, d); chk(d, rows[i].exp);
            chk(32'(MRD_XFER_OK), 32'(!rows[i].td));
        end
        $display("done: status table");
        // interrupt raised, cleared by read, then masked
        // table left tx empty rise, rx set rise and tx set fall behind
        rd(8'h18, d); chk(d, 32'h7);
        wr(8'h1C, 32'hF);
        i_core.set_ep(1'b0, 1'b0, 1'b0); i_core.set_ep(1'b1, 1'b0, 1'b0);
        waitc(6); chk(32'(IRQ), 32'h1);
        rd(8'h18, d); chk(d, 32'h1);
        waitc(2); chk(32'(IRQ), 32'h0);
        wr(8'h1C, 32'h0); i_core.set_ep(1'b1, 1'b0, 1'b1);
        waitc(6); chk(32'(IRQ), 32'h0);
        rd(8'h18, d); chk(d, 32'h2);
        rd(8'h18, d); chk(d, 32'h0);
        $display("done: interrupt");
        // counter runs from rx empty, hidden unless enabled
        i_core.set_ep(1'b1, 1'b0, 1'b0); waitc(5);
        i_core.ticks(5); waitc(6);
        cnt_read(d); chk(d, 32'hFFFFFFFA);
        wr(8'h04, 32'h0); cnt_read(d); chk(d, 32'h0);
        rd(8'h0C, d); chk(d, 32'h0);
        $display("done: timeout counter");
        // read-only status, unmapped address
        wr(8'h00, 32'hFFFFFFFF); rd(8'h00, d); chk(d, 32'h0000001C);
        rd(8'h40, d); chk(d, 32'h0);
        $display("done: reserved");
        // zero-length send only once the endpoint reads empty
        chk(32'(EPTX_EMPTY), 32'h1);
        rd(8'h00, d); chk(d & 32'h10, 32'h10);
        wr(8'h14, 32'h1); #1 chk(32'(ZERO_LEN_TX), 32'h1);
        @(posedge REF_CLK); #1 chk(32'(ZERO_LEN_TX), 32'h0);
        chk(32'(zlp_seen), 32'h1);
        $display("done: zero length");
        // reset in mid-run reloads a counter that has moved
        wr(8'h04, 32'h1); i_core.set_ep(1'b1, 1'b0, 1'b1); waitc(5);
        i_core.set_ep(1'b1, 1'b0, 1'b0); waitc(5); i_core.ticks(2);
        @(posedge REF_CLK); RESETN <= 1'b0;
        @(posedge REF_CLK); #1 chk(32'(MRD_XFER_OK), 32'h1);
        chk(REG_RDATA, 32'h0); chk(32'(IRQ), 32'h0);
        waitc(3); RESETN <= 1'b1;
        wr(8'h04, 32'h1); cnt_read(d); chk(d, 32'hFFFFFFFF);
        $display("done: mid-run reset");
        end_of_test();
    end
endmodule : usb_dma_bridge_status_tb
